//--- rtl/vamc_control.v
// Converter control: sequences conversions, stores results and checks limits.
// Assumes an external converter and a byte register port from the bus slave.
`timescale 1ns/100ps
`include "vamc_defs.vh"

module vamc_control #(
   parameter CONV_CYCLES = `VAMC_CONV_CYCLES
) (
   // Clock and reset.
   input  wire       clk_in,
   input  wire       rstn_in,
   // Register port from the bus slave.
   input  wire [7:0] reg_addr_in,
   input  wire [7:0] reg_wdata_in,
   input  wire       reg_wr_in,
   input  wire       reg_rd_in,
   output reg  [7:0] reg_rdata_out,
   // Converter port.
   output reg        adc_start_out,
   output reg  [2:0] adc_channel_out,
   output wire       adc_bypass_out,
   output wire       adc_supply_5v_out,
   output wire       adc_temp_signed_out,
   input  wire       adc_done_in,
   input  wire [9:0] adc_data_in,
   // Open-drain alert pin.
   output wire       smbalert_n_out,
   output wire       smbalert_oe_n_out
);

   // ************************************************************
   // Registers
   // ************************************************************
   reg  [7:0] low_limit_2v5;                // 2.5 V low limit.
   reg  [7:0] high_limit_2v5;               // 2.5 V high limit.
   reg  [7:0] tach_min_high_channel_select; // Channel select in bits 7:5.
   reg  [7:0] adc_config_one;               // Supply scaling and timeout.
   reg  [7:0] adc_config_two;               // Averaging, bypass, single mode.
   reg  [7:0] alert_mask;                   // Masks status bits off the alert.
   reg  [1:0] status;                       // Sticky limit flags.
   reg  [9:0] volt_2v5;                     // Latest 2.5 V result.
   reg  [9:0] volt_supply;                  // Latest supply result.
   reg  [9:0] local_temp;                   // Visible local temperature.
   reg  [9:0] temp_pending;                 // Result held back while frozen.
   reg        pending;                      // Held result waiting.
   reg        frozen;                       // Temperature registers frozen.
   reg  [12:0] slot;                        // Cycle count within a slot.
   reg        result_seen;                  // A result finished since the last slot start.

   wire       avg_off  = adc_config_two[`VAMC_CFG2_AVG_OFF];
   wire       single   = adc_config_two[`VAMC_CFG2_SINGLE];
   wire [2:0] sel_chan = tach_min_high_channel_select[7:5];
   wire       res_valid;                    // Averaged result strobe.
   wire [9:0] res;                          // Averaged result.
   wire       chan_change;                  // Channel moves on next slot.
   reg  [2:0] next_channel;                 // Channel for the next run.
   wire       wr_2v5;                       // New 2.5 V result written.
   wire       set_low;                      // 2.5 V below its low limit.
   wire       set_high;                     // 2.5 V above its high limit.
   wire       rd_status;                    // Status register is read.

   // ************************************************************
   // Converter sequencing
   // ************************************************************
   assign adc_bypass_out      = adc_config_two[`VAMC_CFG2_BYPASS];
   assign adc_supply_5v_out   = adc_config_one[`VAMC_CFG1_SUPPLY_5V];
   assign adc_temp_signed_out = (adc_channel_out == `VAMC_CHAN_LOCAL_TEMP);

   // Picks the next channel: round robin, or the selected one alone.
   always @* begin
      if (single) begin
         next_channel = sel_chan;
      end else begin
         case (adc_channel_out)
            `VAMC_CHAN_2V5:    next_channel = `VAMC_CHAN_SUPPLY;
            `VAMC_CHAN_SUPPLY: next_channel = `VAMC_CHAN_LOCAL_TEMP;
            default:           next_channel = `VAMC_CHAN_2V5;
         endcase
      end
   end

   // The channel changes at a slot start after a finished result, or at the next slot start in single mode or with averaging off.
   // A result lands mid-slot, so it is remembered until the next slot boundary.
   assign chan_change = (slot == 13'h0000) && (next_channel != adc_channel_out) &&
                        (res_valid || result_seen || single || avg_off);

   // Starts one conversion per slot of the conversion time.
   always @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         slot            <= 13'h0000;
         adc_start_out   <= 1'b0;
         adc_channel_out <= `VAMC_CHAN_2V5;
         result_seen     <= 1'b0;
      end else begin
         adc_start_out <= (slot == 13'h0000);
         // Kept until the slot boundary, where the channel step uses it up.
         result_seen   <= (res_valid | result_seen) & (slot != 13'h0000);
         if (slot == CONV_CYCLES - 1) begin
            slot <= 13'h0000;
         end else begin
            slot <= slot + 13'h0001;
         end
         if (chan_change) begin
            adc_channel_out <= next_channel;
         end
      end
   end

   // Averages sixteen codes, or passes each through when averaging is off.
   vamc_averager u_avg (
      .clk_in           (clk_in),
      .rstn_in          (rstn_in),
      .sample_valid_in  (adc_done_in),
      .sample_in        (adc_data_in),
      .signed_in        (adc_temp_signed_out),
      .single_in        (avg_off),
      .clear_in         (chan_change),
      .result_valid_out (res_valid),
      .result_out       (res)
   );

   // ************************************************************
   // Results and limit checks
   // ************************************************************
   assign wr_2v5    = res_valid && (adc_channel_out == `VAMC_CHAN_2V5);
   assign set_low   = wr_2v5 && (res[9:2] < low_limit_2v5);
   assign set_high  = wr_2v5 && (res[9:2] > high_limit_2v5);
   assign rd_status = reg_rd_in && (reg_addr_in == `VAMC_ADDR_STATUS);

   // Stores results; temperature updates wait while the registers are frozen.
   always @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         volt_2v5     <= 10'h000;
         volt_supply  <= 10'h000;
         local_temp   <= {`VAMC_RST_LOCAL_TEMP, 2'b00};
         temp_pending <= 10'h000;
         pending      <= 1'b0;
         frozen       <= 1'b0;
         status       <= 2'b00;
      end else begin
         if (wr_2v5) begin
            volt_2v5 <= res;
         end
         if (res_valid && (adc_channel_out == `VAMC_CHAN_SUPPLY)) begin
            volt_supply <= res;
         end
         if (res_valid && adc_temp_signed_out && frozen) begin
            temp_pending <= res;
            pending      <= 1'b1;
         end else if (res_valid && adc_temp_signed_out) begin
            // A fresh result supersedes any older held one.
            local_temp <= res;
            pending    <= 1'b0;
         end else if (!frozen && pending) begin
            local_temp <= temp_pending;
            pending    <= 1'b0;
         end
         // Reading the low bits freezes, reading the high byte releases.
         if (reg_rd_in && (reg_addr_in == `VAMC_ADDR_EXT_RES)) begin
            frozen <= 1'b1;
         end else if (reg_rd_in && (reg_addr_in == `VAMC_ADDR_LOCAL_TEMP)) begin
            frozen <= 1'b0;
         end
         // A new violation wins over a read that clears the flags.
         status[`VAMC_STAT_LOW_2V5]  <= set_low  | (status[`VAMC_STAT_LOW_2V5]  & ~rd_status);
         status[`VAMC_STAT_HIGH_2V5] <= set_high | (status[`VAMC_STAT_HIGH_2V5] & ~rd_status);
      end
   end

   // Alert pulls low while any unmasked flag is set.
   assign smbalert_n_out    = 1'b0;
   assign smbalert_oe_n_out = ~|(status & ~alert_mask[1:0]);

   // ************************************************************
   // Register port
   // ************************************************************
   // Holds software writes; reset values keep the limits quiet.
   always @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         low_limit_2v5                <= `VAMC_RST_LOW_2V5;
         high_limit_2v5               <= `VAMC_RST_HIGH_2V5;
         tach_min_high_channel_select <= `VAMC_RST_ZERO;
         adc_config_one               <= `VAMC_RST_ZERO;
         adc_config_two               <= `VAMC_RST_ZERO;
         alert_mask                   <= `VAMC_RST_ZERO;
      end else if (reg_wr_in) begin
         case (reg_addr_in)
            `VAMC_ADDR_LOW_2V5:     low_limit_2v5                <= reg_wdata_in;
            `VAMC_ADDR_HIGH_2V5:    high_limit_2v5               <= reg_wdata_in;
            `VAMC_ADDR_CHAN_SELECT: tach_min_high_channel_select <= reg_wdata_in;
            `VAMC_ADDR_CONFIG_ONE:  adc_config_one               <= reg_wdata_in;
            `VAMC_ADDR_CONFIG_TWO:  adc_config_two               <= reg_wdata_in;
            `VAMC_ADDR_ALERT_MASK:  alert_mask                   <= reg_wdata_in;
            default:                alert_mask                   <= alert_mask;
         endcase
      end
   end

   // Returns read data one cycle after the read strobe; unmapped reads give zero.
   always @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_rd_in) begin
         case (reg_addr_in)
            `VAMC_ADDR_VOLT_2V5:    reg_rdata_out <= volt_2v5[9:2];
            `VAMC_ADDR_VOLT_SUPPLY: reg_rdata_out <= volt_supply[9:2];
            `VAMC_ADDR_LOCAL_TEMP:  reg_rdata_out <= local_temp[9:2];
            `VAMC_ADDR_EXT_RES:     reg_rdata_out <= {2'b00, local_temp[1:0], 4'h0};
            `VAMC_ADDR_STATUS:      reg_rdata_out <= {6'h00, status};
            `VAMC_ADDR_LOW_2V5:     reg_rdata_out <= low_limit_2v5;
            `VAMC_ADDR_HIGH_2V5:    reg_rdata_out <= high_limit_2v5;
            `VAMC_ADDR_CHAN_SELECT: reg_rdata_out <= tach_min_high_channel_select;
            `VAMC_ADDR_CONFIG_ONE:  reg_rdata_out <= adc_config_one;
            `VAMC_ADDR_CONFIG_TWO:  reg_rdata_out <= adc_config_two;
            `VAMC_ADDR_ALERT_MASK:  reg_rdata_out <= alert_mask;
            default:                reg_rdata_out <= 8'h00;
         endcase
      end
   end

endmodule

//--- rtl/vamc_defs.vh
// Constants for the voltage and temperature converter control block.
// Assumes a 10 MHz system clock and a byte-wide register port.
`ifndef VAMC_DEFS_VH
`define VAMC_DEFS_VH

// ************************************************************
// Register offsets
// ************************************************************
`define VAMC_ADDR_VOLT_2V5     8'h20
`define VAMC_ADDR_VOLT_SUPPLY  8'h21
`define VAMC_ADDR_LOCAL_TEMP   8'h26
`define VAMC_ADDR_CONFIG_ONE   8'h40
`define VAMC_ADDR_STATUS       8'h41
`define VAMC_ADDR_LOW_2V5      8'h44
`define VAMC_ADDR_HIGH_2V5     8'h45
`define VAMC_ADDR_CHAN_SELECT  8'h55
`define VAMC_ADDR_CONFIG_TWO   8'h73
`define VAMC_ADDR_ALERT_MASK   8'h74
`define VAMC_ADDR_EXT_RES      8'h77

// ************************************************************
// Reset values
// ************************************************************
`define VAMC_RST_LOW_2V5       8'h00
`define VAMC_RST_HIGH_2V5      8'hff
`define VAMC_RST_VOLT          8'h00
`define VAMC_RST_LOCAL_TEMP    8'h80
`define VAMC_RST_ZERO          8'h00

// ************************************************************
// Field positions
// ************************************************************
`define VAMC_CFG1_SUPPLY_5V    7
`define VAMC_CFG2_AVG_OFF      4
`define VAMC_CFG2_BYPASS       5
`define VAMC_CFG2_SINGLE       6
`define VAMC_STAT_LOW_2V5      0
`define VAMC_STAT_HIGH_2V5     1

// ************************************************************
// Channel codes
// ************************************************************
`define VAMC_CHAN_2V5          3'h0
`define VAMC_CHAN_SUPPLY       3'h2
`define VAMC_CHAN_LOCAL_TEMP   3'h6

// ************************************************************
// Timing
// ************************************************************
`define VAMC_CLK_PERIOD_NS     100
`define VAMC_CONV_TIME_NS      711000
`define VAMC_CONV_CYCLES       (`VAMC_CONV_TIME_NS / `VAMC_CLK_PERIOD_NS)
`define VAMC_AVG_SAMPLES       16

`endif

//--- rtl/vamc_averager.v
// Sample averager: sums a run of converter codes and returns their mean.
// Assumes samples arrive as one-cycle strobes from the converter sequencer.
`timescale 1ns/100ps
`include "vamc_defs.vh"

module vamc_averager #(
   parameter SAMPLES = `VAMC_AVG_SAMPLES
) (
   // Clock and reset.
   input  wire       clk_in,
   input  wire       rstn_in,
   // Sample side.
   input  wire       sample_valid_in,
   input  wire [9:0] sample_in,
   input  wire       signed_in,
   input  wire       single_in,
   input  wire       clear_in,
   // Result side.
   output reg        result_valid_out,
   output reg  [9:0] result_out
);

   // ************************************************************
   // Accumulator
   // ************************************************************
   reg  [13:0] sum;        // Running total of extended samples.
   reg  [4:0]  count;      // Samples taken in the current run.
   wire [13:0] ext;        // Sample extended to the total's width.
   wire [13:0] total;      // Total including the present sample.

   // Temperature codes are signed, voltage codes are not.
   assign ext   = {{4{signed_in & sample_in[9]}}, sample_in};
   assign total = sum + ext;

   // Accumulates samples and emits the mean of a full run.
   always @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         sum              <= 14'h0000;
         count            <= 5'h00;
         result_valid_out <= 1'b0;
         result_out       <= 10'h000;
      end else begin
         result_valid_out <= 1'b0;
         if (clear_in) begin
            // A channel change discards a part-filled run.
            sum   <= 14'h0000;
            count <= 5'h00;
         end else if (sample_valid_in) begin
            if (single_in) begin
               // Averaging off: each conversion is a result.
               result_out       <= sample_in;
               result_valid_out <= 1'b1;
               sum              <= 14'h0000;
               count            <= 5'h00;
            end else if (count == SAMPLES - 1) begin
               // Divide by sixteen keeps the sign of signed codes.
               result_out       <= total[13:4];
               result_valid_out <= 1'b1;
               sum              <= 14'h0000;
               count            <= 5'h00;
            end else begin
               sum   <= total;
               count <= count + 5'h01;
            end
         end
      end
   end

endmodule

//--- testbench/vamc_control_monitor.sv
// Concurrent checks on the ports of the converter control block.
// Assumes it is bound onto vamc_control with the same slot length.
`timescale 1ns/100ps
`include "vamc_defs.vh"
module vamc_control_monitor #(
   parameter int CONV_CYCLES = 20
) (
   // Clock and reset.
   input wire       clk_in,
   input wire       rstn_in,
   // Register port.
   input wire [7:0] reg_addr_in,
   input wire [7:0] reg_wdata_in,
   input wire       reg_wr_in,
   input wire       reg_rd_in,
   input wire [7:0] reg_rdata_out,
   // Converter port and alert pin.
   input wire       adc_start_out,
   input wire [2:0] adc_channel_out,
   input wire       adc_bypass_out,
   input wire       adc_supply_5v_out,
   input wire       adc_temp_signed_out,
   input wire       adc_done_in,
   input wire [9:0] adc_data_in,
   input wire       smbalert_n_out,
   input wire       smbalert_oe_n_out
);
   // *****************************
   // Clocking and write-read steps
   // *****************************
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rstn_in);
   // A write of the high limit followed by a read of it.
   sequence s_wr_high;
      reg_wr_in && reg_addr_in == 8'h45;
   endsequence
   sequence s_rd_high;
      reg_rd_in && reg_addr_in == 8'h45;
   endsequence
   // *****************************
   // Slot timing helper
   // *****************************
   // Cycles since the last start pulse; the seed makes the first pulse after reset count as on time.
   logic [15:0] start_gap;
   always @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         start_gap <= 16'(CONV_CYCLES - 1);
      end else if (adc_start_out) begin
         start_gap <= 16'h0001;
      end else if (start_gap != 16'hffff) begin
         start_gap <= start_gap + 16'h0001;
      end
   end
   // *****************************
   // Assertions
   // *****************************
   a_high_limit_readback: assert property (
      s_wr_high ##2 s_rd_high |=> reg_rdata_out == $past(reg_wdata_in, 3))
      else $error("High limit read back differs from write");
   a_read_data_holds: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
      else $error("Read data moved without a read");
   a_unmapped_reads_zero: assert property (reg_rd_in && reg_addr_in == 8'h00 |=> reg_rdata_out == 8'h00)
      else $error("Unmapped read not zero");
   a_start_one_cycle: assert property (adc_start_out |=> !adc_start_out)
      else $error("Start pulse longer than one cycle");
   a_start_period: assert property (adc_start_out |-> start_gap == CONV_CYCLES)
      else $error("Start pulses not one slot apart");
   a_start_not_late: assert property (start_gap <= CONV_CYCLES)
      else $error("Start pulse missing after a slot");
   a_channel_at_slot: assert property ($changed(adc_channel_out) |-> ##[0:1] adc_start_out)
      else $error("Channel changed inside a slot");
   a_temp_signed_flag: assert property (
      adc_temp_signed_out == (adc_channel_out == `VAMC_CHAN_LOCAL_TEMP))
      else $error("Signed flag does not match channel");
   a_bypass_follows: assert property (
      reg_wr_in && reg_addr_in == 8'h73 |=> adc_bypass_out == $past(reg_wdata_in[5]))
      else $error("Bypass level does not follow write");
   a_supply_follows: assert property (
      reg_wr_in && reg_addr_in == 8'h40 |=> adc_supply_5v_out == $past(reg_wdata_in[7]))
      else $error("Supply scaling does not follow write");
   a_alert_data_low: assert property (smbalert_n_out == 1'b0)
      else $error("Alert data not low");
   // The alert pin is pulled at least once.
   c_alert_pulled: cover property ($fell(smbalert_oe_n_out));
endmodule
bind vamc_control vamc_control_monitor #(.CONV_CYCLES(CONV_CYCLES)) i_monitor (.clk_in(clk_in), .rstn_in(rstn_in),
   .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
   .reg_rdata_out(reg_rdata_out), .adc_start_out(adc_start_out), .adc_channel_out(adc_channel_out),
   .adc_bypass_out(adc_bypass_out), .adc_supply_5v_out(adc_supply_5v_out), .adc_temp_signed_out(adc_temp_signed_out),
   .adc_done_in(adc_done_in), .adc_data_in(adc_data_in), .smbalert_n_out(smbalert_n_out),
   .smbalert_oe_n_out(smbalert_oe_n_out));

//--- testbench/vamc_adc_model.sv
// Behavioural converter on the far side of the conversion port.
// Assumes one start pulse per slot and a reply delay shorter than a slot.
`timescale 1ns/100ps
module vamc_adc_model (
   // Clock and reset.
   input  wire       clk_in,
   input  wire       rstn_in,
   // Request from the block.
   input  wire       start_in,
   input  wire [2:0] chan_in,
   // Reply delay, ramp enable and per-channel codes.
   input  wire [3:0] lat_in,
   input  wire       ramp_in,
   input  wire [9:0] code_2v5_in,
   input  wire [9:0] code_sup_in,
   input  wire [9:0] code_tmp_in,
   // Reply to the block.
   output reg        done_out,
   output reg  [9:0] data_out
);
   reg [4:0] wait_cnt;   // Cycles left until the reply.
   reg [3:0] ramp_cnt;   // Offset added to each code while ramping.
   reg [9:0] code;       // Code of the channel under conversion.
   // Pick the code for the selected channel.
   always @* begin
      case (chan_in)
         3'h0: code = code_2v5_in;
         3'h2: code = code_sup_in;
         default: code = code_tmp_in;
      endcase
   end
   // One reply per start; the data line toggles between replies so a stale code never looks valid.
   always @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wait_cnt <= 5'h00;
         ramp_cnt <= 4'h0;
         done_out <= 1'b0;
         data_out <= 10'h000;
      end else begin
         done_out <= 1'b0;
         data_out <= ~data_out;
         if (start_in) begin
            wait_cnt <= {1'b0, lat_in} + 5'h01;
         end else if (wait_cnt != 5'h00) begin
            wait_cnt <= wait_cnt - 5'h01;
            // Reply when the delay runs out, with a 10-bit straight code.
            if (wait_cnt == 5'h01) begin
               done_out <= 1'b1;
               data_out <= code + (ramp_in ? {6'h00, ramp_cnt} : 10'h000);
               ramp_cnt <= ramp_cnt + 4'h1;
            end
         end
      end
   end
endmodule

//--- testbench/voltage_adc_monitor_control_bench.sv
// Self-checking bench for the converter control block.
// Assumes the converter model and a slot shortened to 20 cycles.
`timescale 1ns/100ps
module voltage_adc_monitor_control_bench;
   localparam SLOT = 20;   // Shortened conversion slot.
   reg        clk_in = 1'b0;
   reg        rstn_in = 1'b0;
   reg  [7:0] reg_addr_in = 8'h00;
   reg  [7:0] reg_wdata_in = 8'h00;
   reg        reg_wr_in = 1'b0;
   reg        reg_rd_in = 1'b0;
   reg  [3:0] lat = 4'h2;   // Prompt replies first, slow ones later.
   reg        ramp = 1'b1;  // Ramp makes the average differ from the last sample.
   reg  [9:0] c2v5 = 10'h300;
   reg  [9:0] csup = 10'h2a0;
   reg  [9:0] ctmp = 10'h39c;
   wire [7:0] reg_rdata_out;
   wire [2:0] adc_channel_out;
   wire [9:0] adc_data_in;
   wire       adc_start_out, adc_bypass_out, adc_supply_5v_out, adc_temp_signed_out;
   wire       adc_done_in, smbalert_n_out, smbalert_oe_n_out;
   integer    num_errors = 0;
   integer    n_compared = 0;
   integer    i;
   integer    k;
   // Free-running 10 MHz clock.
   always #50 clk_in = ~clk_in;
   vamc_control #(.CONV_CYCLES(SLOT)) i_dut (.clk_in(clk_in), .rstn_in(rstn_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
      .adc_start_out(adc_start_out), .adc_channel_out(adc_channel_out), .adc_bypass_out(adc_bypass_out),
      .adc_supply_5v_out(adc_supply_5v_out), .adc_temp_signed_out(adc_temp_signed_out), .adc_done_in(adc_done_in),
      .adc_data_in(adc_data_in), .smbalert_n_out(smbalert_n_out), .smbalert_oe_n_out(smbalert_oe_n_out));
   vamc_adc_model i_adc (.clk_in(clk_in), .rstn_in(rstn_in), .start_in(adc_start_out), .chan_in(adc_channel_out),
      .lat_in(lat), .ramp_in(ramp), .code_2v5_in(c2v5), .code_sup_in(csup), .code_tmp_in(ctmp),
      .done_out(adc_done_in), .data_out(adc_data_in));
   // Prints the counts and the verdict, then stops.
   task complete_run;
      begin
         $display("Compared %0d, mismatches %0d", n_compared, num_errors);
         if (num_errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
         end else begin
            $display("Testbench failed");
         end
         $finish;
      end
   endtask
   // Compares one value with its expectation.
   task chk(input [7:0] seen, input [7:0] exp);
      begin
         n_compared = n_compared + 1;
         if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
         end
      end
   endtask
   // One write strobe, held for one sampling edge.
   task wr(input [7:0] a, input [7:0] d);
      begin
         @(posedge clk_in);
         reg_wr_in <= 1'b1;
         reg_addr_in <= a;
         reg_wdata_in <= d;
         @(posedge clk_in);
         reg_wr_in <= 1'b0;
      end
   endtask
   // One read strobe; the data is looked at once the answering edge has landed.
   task rd(input [7:0] a, input [7:0] exp);
      begin
         @(posedge clk_in);
         reg_rd_in <= 1'b1;
         reg_addr_in <= a;
         @(posedge clk_in);
         reg_rd_in <= 1'b0;
         @(posedge clk_in);
         #1;
         chk(reg_rdata_out, exp);
      end
   endtask
   // Lets whole slots pass.
   task slots(input integer n);
      begin
         repeat (n * SLOT) @(posedge clk_in);
         #1;
      end
   endtask
   // Waits for the next start pulse, giving up after two slots.
   task next_start;
      begin
         @(posedge clk_in);
         #1;
         for (i = 0; i < 2 * SLOT && adc_start_out !== 1'b1; i = i + 1) begin
            @(posedge clk_in);
            #1;
         end
         if (adc_start_out !== 1'b1) begin
            num_errors = num_errors + 1;
            $display("Error at %0t: no start pulse", $time);
            complete_run;
         end
      end
   endtask
   // Main sequence.
   initial begin
      repeat (4) @(posedge clk_in);
      rstn_in <= 1'b1;
      rd(8'h44, 8'h00);
      rd(8'h45, 8'hff);
      rd(8'h20, 8'h00);
      rd(8'h77, 8'h00);
      rd(8'h26, 8'h80);
      rd(8'h00, 8'h00);
      wr(8'h26, 8'h55);
      rd(8'h26, 8'h80);
      wr(8'h45, 8'h5a);
      rd(8'h45, 8'h5a);
      wr(8'h45, 8'hff);
      wr(8'h55, 8'h40);
      rd(8'h55, 8'h40);
      // First round: each result is the mean of 16 ramped samples.
      slots(56);
      rd(8'h20, 8'hc1);
      rd(8'h21, 8'ha9);
      rd(8'h77, 8'h30);
      rd(8'h26, 8'he8);
      // High limit below the result, then masked and unmasked.
      wr(8'h45, 8'hc0);
      slots(50);
      wr(8'h74, 8'h02);
      #1;
      chk({7'h00, smbalert_oe_n_out}, 8'h01);
      wr(8'h74, 8'h00);
      #1;
      chk({7'h00, smbalert_oe_n_out}, 8'h00);
      rd(8'h41, 8'h02);
      // Low limit above the result.
      wr(8'h45, 8'hff);
      wr(8'h44, 8'hc2);
      slots(50);
      chk({7'h00, smbalert_oe_n_out}, 8'h00);
      rd(8'h41, 8'h01);
      // Single channel without averaging, slow replies.
      ramp <= 1'b0;
      lat <= 4'hf;
      c2v5 <= 10'h3fc;
      csup <= 10'h1ff;
      wr(8'h44, 8'h00);
      wr(8'h55, 8'h00);
      wr(8'h73, 8'h50);
      rd(8'h73, 8'h50);
      slots(4);
      rd(8'h20, 8'hff);
      wr(8'h55, 8'h40);
      slots(2);
      for (k = 0; k < 3; k = k + 1) begin
         next_start;
         chk({5'h00, adc_channel_out}, 8'h02);
      end
      rd(8'h21, 8'h7f);
      wr(8'h40, 8'h80);
      wr(8'h73, 8'h70);
      #1;
      chk({6'h00, adc_supply_5v_out, adc_bypass_out}, 8'h03);
      // Freeze of the temperature pair.
      ctmp <= 10'h066;
      wr(8'h55, 8'hc0);
      slots(3);
      rd(8'h77, 8'h20);
      ctmp <= 10'h3fc;
      slots(3);
      rd(8'h26, 8'h19);
      rd(8'h77, 8'h00);
      rd(8'h26, 8'hff);
      complete_run;
   end
endmodule
